/* File: mcu_irq_status_ctrl.sv */
// interrupt controller and processor status/control logic
// Function
// (R1) writing suspend bit halts CPU, suspends
// (R2) interrupt or bus activity wakes, resumes next
// (R3) suspend entered even with wake pending
// (R4) hardware clears suspend bit on resume
// (R5) bit 2 reads global enable, unwritable
// (R6) software writes zero to reserved bit 1
// (R7) halt clears run, stops until reset
// (R8) power-up or low-voltage reset loads 00010001
// (R9) watchdog after power-up reads 01010001
// (R10) watchdog reset gives 01XX0001
// (R11) bus reset before read sets event bit
// (R12) enables set by one, cleared by reset
// (R13) one sticky pending flop per source
// (R14) enabled request served at instruction end
// (R15) ack clears enable, pending, then calls vector
// (R16) call saves PC and flags; return re-enables
// (R17) mask/unmask touch only global enable
// (R18) bit 7 shows any pending interrupt
// (R19) priority follows vector number, 1 highest
// (R20) vectors two bytes apart from zero
// (R21) latency adds 10 call, 5 jump cycles
// (R22) enable register layout, reserved, reset zero
// (R23) bus event bit sticky after 128 us
// (R24) watchdog bit set on rollover, cleared by LOW_VOLTAGE_RESET
// (R25) reserved vectors 6 to 9 never requested
// (R26) reserved enable bits read zero
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "isc_regs.svh"
module mcu_irq_status_ctrl #(
    parameter int BUS_EVENT_CYCLES = `BUS_EVENT_MIN_US * `CLOCK_MHZ,
    parameter int WAKE_CYCLES      = `WAKE_START_CYCLES
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  low_voltage_reset,
    input  wire logic                  watchdog_reset,
    input  wire isc_pkg::reg_req_t     reg_req,
    output logic [7:0]                 reg_rdata,
    input  wire logic                  instr_done,
    input  wire isc_pkg::cpu_ops_t     cpu_ops,
    input  wire isc_pkg::call_frame_t  cpu_frame,
    input  wire logic                  bus_condition,
    input  wire logic                  bus_activity,
    input  wire logic                  timer_128us,
    input  wire logic                  timer_1024us,
    input  wire logic                  endpoint0_event,
    input  wire logic                  endpoint1_event,
    input  wire logic                  gpio_event,
    input  wire logic                  wakeup_event,
    output logic                       cpu_stall,
    output logic                       service_call,
    output logic                       service_entry,
    output logic [15:0]                vector_addr,
    output isc_pkg::call_frame_t       call_frame,
    output logic                       suspended,
    output logic                       running
);
    localparam int NSRC = 7;
    localparam int CALL_CNT = `CALL_CYCLES * `CLOCK_MHZ / `CLOCK_MHZ;
    localparam int JUMP_CNT = `JUMP_CYCLES * `CLOCK_MHZ / `CLOCK_MHZ;
    localparam int CW = $clog2(WAKE_CYCLES + CALL_CNT + 1);

    isc_pkg::cpu_state_t state;
    logic [CW-1:0]       count;
    logic [7:0]          gie;
    logic [7:0]          epe;
    logic                global_en;
    logic                wdr_flag;
    logic                lvr_flag;
    logic                busev_flag;
    logic                susp_bit;
    logic                run_bit;
    logic [NSRC-1:0]     pending;
    logic [NSRC-1:0]     src_set;
    logic [NSRC-1:0]     src_en;
    logic [NSRC-1:0]     request;
    logic                req_valid;
    logic [2:0]          req_idx;
    logic                ack;
    logic                bus_event;
    logic                any_reset;
    logic                power_reset;
    logic                wr_gie;
    logic                wr_epe;
    logic                wr_psc;
    logic                wake_cond;
    logic                wake_done;
    logic [7:0]          psc_value;

    // vector number of each source slot; slots 6..9 of the table have no source
    function automatic logic [3:0] vec_num(input logic [2:0] idx);
        case (idx)
            3'h0: vec_num = `VEC_BUS;
            3'h1: vec_num = `VEC_T128;
            3'h2: vec_num = `VEC_T1024;
            3'h3: vec_num = `VEC_EP0;
            3'h4: vec_num = `VEC_EP1;
            3'h5: vec_num = `VEC_GPIO;
            default: vec_num = `VEC_WAKE;
        endcase
    endfunction

    function automatic logic is_addr(input isc_pkg::reg_req_t r, input logic [7:0] a);
        return r.addr == a;
    endfunction

    // power-on and low-voltage resets act alike on flags, enables and sequencer; only rst clears vector_addr and reg_rdata
    assign power_reset = rst || low_voltage_reset;
    assign any_reset   = power_reset || watchdog_reset;
    assign wr_gie      = reg_req.write && is_addr(reg_req, `GIE_ADDR);
    assign wr_epe      = reg_req.write && is_addr(reg_req, `EPE_ADDR);
    assign wr_psc      = reg_req.write && is_addr(reg_req, `PSC_ADDR);

    isc_bus_event #(
        .CYCLES (BUS_EVENT_CYCLES)
    ) u_bus_event (
        .clock       (clock),
        .rst         (any_reset),
        .condition   (bus_condition),
        .event_pulse (bus_event)
    );

    assign src_set = {wakeup_event, gpio_event, endpoint1_event, endpoint0_event,
                      timer_1024us, timer_128us, bus_event};
    assign src_en  = {gie[`GIE_WAKE], gie[`GIE_GPIO], epe[`EPE_EP1_HI] | epe[`EPE_EP1_LO],
                      epe[`EPE_EP0], gie[`GIE_T1024], gie[`GIE_T128], gie[`GIE_BUS]};
    assign request = pending & src_en; // R14 R25

    isc_priority #(
        .N  (NSRC),
        .IW (3)
    ) u_priority (
        .request (request),
        .valid   (req_valid),
        .index   (req_idx)
    );

    // taken only between instructions, with the core otherwise idle
    assign ack = (state == isc_pkg::ST_IDLE) && instr_done && global_en && req_valid // R14 R19
                 && !any_reset && !(wr_psc && reg_req.wdata[`PSC_SUSP]) && !cpu_ops.halt
                 && !(wr_psc && !reg_req.wdata[`PSC_RUN]);

    // enable registers
    always_ff @(posedge clock) begin
        if (any_reset) begin
            gie <= `GIE_RESET; // R12 R22
            epe <= `EPE_RESET; // R12
        end else begin
            if (wr_gie) begin
                gie <= reg_req.wdata & `GIE_MASK; // R12 R22 R26
            end
            if (wr_epe) begin
                epe <= reg_req.wdata & `EPE_MASK; // R12
            end
        end
    end

    // global enable: only the instructions and the acknowledge touch it
    always_ff @(posedge clock) begin
        if (any_reset) begin
            global_en <= 1'b0; // R12
        end else if (ack) begin
            global_en <= 1'b0; // R15
        end else if (cpu_ops.mask_all) begin
            global_en <= 1'b0; // R17
        end else if (cpu_ops.unmask_all || cpu_ops.return_from_service) begin
            global_en <= 1'b1; // R16 R17
        end
    end

    // one pending flop per source; a new event beats the acknowledge clear
    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : gen_pending
            always_ff @(posedge clock) begin
                if (any_reset) begin
                    pending[g] <= 1'b0; // R13
                end else if (src_set[g]) begin
                    pending[g] <= 1'b1; // R13
                end else if (ack && req_idx == 3'(g)) begin
                    pending[g] <= 1'b0; // R15
                end
            end
        end
    endgenerate

    // reset cause flags
    always_ff @(posedge clock) begin
        if (power_reset) begin
            wdr_flag <= 1'b0; // R24 R8
            lvr_flag <= 1'b1; // R8
        end else if (watchdog_reset) begin
            wdr_flag <= 1'b1; // R10 R24 R9
        end else if (wr_psc) begin
            wdr_flag <= reg_req.wdata[`PSC_WDR];
            lvr_flag <= reg_req.wdata[`PSC_LVR];
        end
    end

    // bus event flag survives a watchdog reset and is set even when disabled
    always_ff @(posedge clock) begin
        if (power_reset) begin
            busev_flag <= 1'b0; // R8
        end else if (bus_event) begin
            busev_flag <= 1'b1; // R23 R11
        end else if (wr_psc && !watchdog_reset) begin
            busev_flag <= reg_req.wdata[`PSC_BUSEV]; // R23
        end
    end

    // wake on an enabled request or bus activity, even if present at entry
    assign wake_cond = (|request) || bus_activity; // R2 R3
    assign wake_done = (state == isc_pkg::ST_WAKE) && (count == CW'(WAKE_CYCLES - 1));

    always_ff @(posedge clock) begin
        if (any_reset) begin
            susp_bit <= 1'b0;
        end else if (wr_psc && reg_req.wdata[`PSC_SUSP] && state == isc_pkg::ST_IDLE) begin
            susp_bit <= 1'b1; // R1
        end else if (wake_done) begin
            susp_bit <= 1'b0; // R4
        end
    end

    always_ff @(posedge clock) begin
        if (any_reset) begin
            run_bit <= 1'b1; // R8 R10
        end else if (cpu_ops.halt && state == isc_pkg::ST_IDLE) begin
            run_bit <= 1'b0; // R7
        end else if (wr_psc && state != isc_pkg::ST_HALTED) begin // R7
            run_bit <= reg_req.wdata[`PSC_RUN];
        end
    end

    // core sequencer: forced call, vector jump, suspend and halt
    always_ff @(posedge clock) begin
        if (any_reset) begin
            state <= isc_pkg::ST_IDLE; // R7
            count <= '0;
        end else begin
            case (state)
                isc_pkg::ST_IDLE: begin
                    count <= '0;
                    if (wr_psc && reg_req.wdata[`PSC_SUSP]) begin
                        state <= isc_pkg::ST_SUSPEND; // R1 R3
                    end else if (cpu_ops.halt || (wr_psc && !reg_req.wdata[`PSC_RUN])) begin
                        state <= isc_pkg::ST_HALTED; // R7
                    end else if (ack) begin
                        state <= isc_pkg::ST_CALL; // R15
                    end
                end
                isc_pkg::ST_CALL: begin
                    if (count == CW'(CALL_CNT - 1)) begin
                        state <= isc_pkg::ST_JUMP; // R21
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                isc_pkg::ST_JUMP: begin
                    if (count == CW'(JUMP_CNT - 1)) begin
                        state <= isc_pkg::ST_IDLE; // R21
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                isc_pkg::ST_SUSPEND: begin
                    count <= '0;
                    if (wake_cond) begin
                        state <= isc_pkg::ST_WAKE; // R2 R3
                    end
                end
                isc_pkg::ST_WAKE: begin
                    // clock start-up delay before the core runs again
                    if (wake_done) begin
                        state <= isc_pkg::ST_IDLE; // R2
                        count <= '0;
                    end else begin
                        count <= count + 1'b1;
                    end
                end
                isc_pkg::ST_HALTED: begin
                    state <= isc_pkg::ST_HALTED; // R7
                end
                default: begin
                    state <= isc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // call target and the frame that the core pushes
    always_ff @(posedge clock) begin
        if (rst) begin
            vector_addr <= 16'h0000; // R20
            call_frame  <= '0;
        end else if (ack) begin
            vector_addr <= {11'h000, vec_num(req_idx), 1'b0}; // R20
            call_frame  <= cpu_frame; // R16
        end
    end

    always_ff @(posedge clock) begin
        if (any_reset) begin
            service_call <= 1'b0;
        end else begin
            service_call <= ack; // R15
        end
    end

    assign service_entry = (state == isc_pkg::ST_JUMP) && (count == CW'(JUMP_CNT - 1));
    assign cpu_stall     = (state != isc_pkg::ST_IDLE);
    assign suspended     = (state == isc_pkg::ST_SUSPEND);
    assign running       = run_bit;

    // bit 1 reads zero whatever software wrote there
    assign psc_value = {|pending, wdr_flag, busev_flag, lvr_flag, // R18
                        susp_bit, global_en, 1'b0, run_bit}; // R5 R6

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (!reg_req.read) begin
            reg_rdata <= 8'h00;
        end else if (is_addr(reg_req, `GIE_ADDR)) begin
            reg_rdata <= gie; // R26
        end else if (is_addr(reg_req, `EPE_ADDR)) begin
            reg_rdata <= epe;
        end else if (is_addr(reg_req, `PSC_ADDR)) begin
            reg_rdata <= psc_value;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    chk_ack_clears_gie: assert property (@(posedge clock) disable iff (any_reset) // R15
        ack |=> !global_en)
        else $error("global enable still set after acknowledge");

    chk_vector_target: assert property (@(posedge clock) disable iff (any_reset) // R20
        ack |=> vector_addr == {11'h000, vec_num($past(req_idx)), 1'b0})
        else $error("vector address wrong for serviced source");

    chk_call_latency: assert property (@(posedge clock) disable iff (any_reset) // R21
        ack |=> (state == isc_pkg::ST_CALL) ##10 (state == isc_pkg::ST_JUMP) ##4 service_entry)
        else $error("call plus jump did not take fifteen cycles");

    chk_priority_order: assert property (@(posedge clock) disable iff (any_reset) // R19
        ack |-> (request & ((7'h01 << req_idx) - 7'h01)) == 7'h00)
        else $error("a higher priority request was passed over");

    chk_suspend_entry: assert property (@(posedge clock) disable iff (any_reset) // R1
        (state == isc_pkg::ST_IDLE && wr_psc && reg_req.wdata[`PSC_SUSP])
        |=> suspended && susp_bit && cpu_stall)
        else $error("suspend write did not suspend the core");

    chk_resume_clears: assert property (@(posedge clock) disable iff (any_reset) // R4
        $fell(susp_bit) && !$past(any_reset)
        |-> $past(state) == isc_pkg::ST_WAKE && state == isc_pkg::ST_IDLE)
        else $error("suspend bit cleared outside resume");

    chk_halt_holds: assert property (@(posedge clock) disable iff (any_reset) // R7
        state == isc_pkg::ST_HALTED |=> state == isc_pkg::ST_HALTED && !running)
        else $error("halted core restarted without reset");

    chk_enable_sense: assert property (@(posedge clock) disable iff (any_reset) // R5
        (reg_req.read && is_addr(reg_req, `PSC_ADDR))
        |=> reg_rdata[`PSC_GIES] == $past(global_en) && reg_rdata[1] == 1'b0)
        else $error("status bit 2 does not mirror global enable");

    chk_power_value: assert property (@(posedge clock) // R8
        power_reset |=> {wdr_flag, busev_flag, lvr_flag, susp_bit, global_en, run_bit}
                        == 6'b001001 && pending == 7'h00)
        else $error("power reset did not load status 00010001");

    chk_watchdog_value: assert property (@(posedge clock) // R10
        (watchdog_reset && !power_reset) |=> wdr_flag && !susp_bit && !global_en && run_bit
            && lvr_flag == $past(lvr_flag) && pending == 7'h00 && gie == 8'h00)
        else $error("watchdog reset status value wrong");

    chk_bus_event_sticky: assert property (@(posedge clock) disable iff (any_reset) // R23
        bus_event |=> busev_flag && pending[0])
        else $error("bus event not recorded");
endmodule

/* File: isc_regs.svh */
// register offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef ISC_REGS_SVH
`define ISC_REGS_SVH

`define GIE_ADDR          8'h20
`define EPE_ADDR          8'h21
`define PSC_ADDR          8'hFF

`define PSC_PENDING       7
`define PSC_WDR           6
`define PSC_BUSEV         5
`define PSC_LVR           4
`define PSC_SUSP          3
`define PSC_GIES          2
`define PSC_RUN           0

`define GIE_WAKE          7
`define GIE_GPIO          6
`define GIE_T1024         2
`define GIE_T128          1
`define GIE_BUS           0
`define GIE_MASK          8'hC7
`define GIE_RESET         8'h00
`define EPE_EP0           0
`define EPE_EP1_LO        1
`define EPE_EP1_HI        2
`define EPE_MASK          8'h07
`define EPE_RESET         8'h00
`define PSC_POR_VALUE     8'h11

`define VEC_BUS           4'h1
`define VEC_T128          4'h2
`define VEC_T1024         4'h3
`define VEC_EP0           4'h4
`define VEC_EP1           4'h5
`define VEC_GPIO          4'hA
`define VEC_WAKE          4'hB

`define CALL_CYCLES       10
`define JUMP_CYCLES       5
`define CLOCK_MHZ         100
`define BUS_EVENT_MIN_US  128
`define WAKE_START_CYCLES 64

`endif

/* File: isc_pkg.sv */
// types shared by the interrupt controller files
package isc_pkg;

    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_CALL    = 6'h02,
        ST_JUMP    = 6'h04,
        ST_SUSPEND = 6'h08,
        ST_WAKE    = 6'h10,
        ST_HALTED  = 6'h20
    } cpu_state_t;

    typedef struct packed {
        logic halt;
        logic mask_all;
        logic unmask_all;
        logic return_from_service;
    } cpu_ops_t;

    typedef struct packed {
        logic [15:0] pc;
        logic        carry_flag;
        logic        zero_flag;
    } call_frame_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       write;
        logic       read;
    } reg_req_t;

endpackage

/* File: isc_priority.sv */
// fixed-priority picker: lowest index wins
`timescale 1ns/1ps
module isc_priority #(
    parameter int N  = 7,
    parameter int IW = 3
) (
    input  wire logic [N-1:0]  request,
    output logic               valid,
    output logic [IW-1:0]      index
);
    function automatic logic [IW-1:0] first_set(input logic [N-1:0] req);
        logic [IW-1:0] idx;
        idx = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (req[k]) begin
                idx = IW'(k);
            end
        end
        return idx;
    endfunction

    assign valid = |request;
    assign index = first_set(request);
endmodule

/* File: isc_bus_event.sv */
// qualifies the selected bus condition once it has lasted long enough
`timescale 1ns/1ps
module isc_bus_event #(
    parameter int CYCLES = 12800
) (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic condition,
    output logic      event_pulse
);
    logic [$clog2(CYCLES+1)-1:0] count;

    // saturates so one long condition gives exactly one event
    always_ff @(posedge clock) begin
        if (rst || !condition) begin
            count <= '0;
        end else if (count != CYCLES[$clog2(CYCLES+1)-1:0]) begin
            count <= count + 1'b1;
        end
    end

    assign event_pulse = condition && (count == CYCLES[$clog2(CYCLES+1)-1:0] - 1'b1);
endmodule

/* File: cpu_core_model.sv */
// core model: ends an instruction every third cycle while not stalled
`timescale 1ns/1ps
module cpu_core_model (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic cpu_stall,
    output logic      instr_done
);
    logic [1:0] phase;

    // three-cycle instructions, so an acknowledge has to wait for a boundary
    always_ff @(posedge clock) begin
        if (rst || cpu_stall || phase == 2'h2)
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    end

    // no boundary while stalled: a stalled core executes nothing
    assign instr_done = (phase == 2'h2) && !cpu_stall;
endmodule

/* File: mcu_interrupt_and_status_ctrl_bench.sv */
// self-checking bench for the interrupt and status controller
`timescale 1ns/1ps
`include "isc_regs.svh"
module mcu_interrupt_and_status_ctrl_bench;
    typedef struct packed {
        int          idx;
        logic [7:0]  gie;
        logic [7:0]  epe;
        logic [15:0] vec;
    } row_t;

    logic                 clock             = 1'b0;
    logic                 rst               = 1'b1;
    logic                 low_voltage_reset = 1'b0;
    logic                 watchdog_reset    = 1'b0;
    logic                 bus_activity      = 1'b0;
    logic [6:0]           ev                = 7'h00;
    isc_pkg::reg_req_t    reg_req           = '0;
    isc_pkg::cpu_ops_t    cpu_ops           = '0;
    isc_pkg::call_frame_t cpu_frame         = '0;
    isc_pkg::call_frame_t call_frame;
    logic [7:0]           reg_rdata;
    logic [7:0]           d;
    logic [15:0]          vector_addr;
    logic                 instr_done;
    logic                 cpu_stall;
    logic                 service_call;
    logic                 service_entry;
    logic                 suspended;
    logic                 running;
    int                   fails             = 0;
    int                   samples_checked   = 0;
    int                   n;
    logic [15:0]          pv [3]            = '{16'h0004, 16'h0014, 16'h0016};
    row_t                 rows [7]          = '{
        '{0, 8'h01, 8'h00, 16'h0002}, '{1, 8'h02, 8'h00, 16'h0004},
        '{2, 8'h04, 8'h00, 16'h0006}, '{3, 8'h00, 8'h01, 16'h0008},
        '{4, 8'h00, 8'h02, 16'h000A}, '{5, 8'h40, 8'h00, 16'h0014},
        '{6, 8'h80, 8'h00, 16'h0016}};

    always #5 clock = ~clock;

    cpu_core_model core_u (
        .clock      (clock),
        .rst        (rst),
        .cpu_stall  (cpu_stall),
        .instr_done (instr_done)
    );

    mcu_irq_status_ctrl #(.BUS_EVENT_CYCLES(20), .WAKE_CYCLES(4)) dut_u (
        .clock             (clock),
        .rst               (rst),
        .low_voltage_reset (low_voltage_reset),
        .watchdog_reset    (watchdog_reset),
        .reg_req           (reg_req),
        .reg_rdata         (reg_rdata),
        .instr_done        (instr_done),
        .cpu_ops           (cpu_ops),
        .cpu_frame         (cpu_frame),
        .bus_condition     (ev[0]),
        .bus_activity      (bus_activity),
        .timer_128us       (ev[1]),
        .timer_1024us      (ev[2]),
        .endpoint0_event   (ev[3]),
        .endpoint1_event   (ev[4]),
        .gpio_event        (ev[5]),
        .wakeup_event      (ev[6]),
        .cpu_stall         (cpu_stall),
        .service_call      (service_call),
        .service_entry     (service_entry),
        .vector_addr       (vector_addr),
        .call_frame        (call_frame),
        .suspended         (suspended),
        .running           (running)
    );

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // one idle cycle after each strobe keeps every signal to one assignment per edge
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock) reg_req <= {a, v, 2'h2};
        @(posedge clock) reg_req <= '0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clock) reg_req <= {a, 8'h00, 2'h1};
        @(posedge clock) reg_req <= '0;
        #1 d = reg_rdata;
    endtask

    task automatic op(input isc_pkg::cpu_ops_t v);
        @(posedge clock) cpu_ops <= v;
        @(posedge clock) cpu_ops <= '0;
    endtask

    task automatic pulse(input int i, input int len);
        @(posedge clock) ev[i] <= 1'b1;
        repeat (len) @(posedge clock);
        ev[i] <= 1'b0;
    endtask

    task automatic serve(input logic [15:0] vec);
        n = 0;
        while (service_call !== 1'b1 && n < 60) begin
            @(posedge clock);
            #1 n++;
        end
        chk(service_call, 1'b1);
        chk(vector_addr, vec);
        chk(call_frame, cpu_frame);
        chk(cpu_stall, 1'b1);
        n = 0;
        while (service_entry !== 1'b1 && n < 60) begin
            @(posedge clock);
            #1 n++;
        end
        chk(service_entry, 1'b1);
        chk(n[17:0], 18'h0000E);
    endtask

    initial begin
        #200000;
        fails++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        rd(`PSC_ADDR);
        chk(d, 8'h11);
        rd(`GIE_ADDR);
        chk(d, 8'h00);
        wr(`GIE_ADDR, 8'hFF);
        rd(`GIE_ADDR);
        chk(d, 8'hC7);
        wr(8'h30, 8'hFF);
        rd(8'h30);
        chk(d, 8'h00);
        wr(`EPE_ADDR, 8'hFF);
        rd(`EPE_ADDR);
        chk(d, 8'h07);
        wr(`PSC_ADDR, 8'hF5);
        rd(`PSC_ADDR);
        chk(d, 8'h71);
        wr(`PSC_ADDR, 8'h01);
        $display("register test done");
        for (int r = 0; r < 7; r++) begin
            wr(`GIE_ADDR, rows[r].gie);
            wr(`EPE_ADDR, rows[r].epe);
            cpu_frame <= {rows[r].vec ^ 16'hF0F0, 2'h2};
            // the bus source needs its condition held past the qualify count
            pulse(rows[r].idx, rows[r].idx == 0 ? 30 : 1);
            rd(`PSC_ADDR);
            chk({d[7], d[5]}, 2'h3);
            op(4'h2);
            serve(rows[r].vec);
            rd(`PSC_ADDR);
            chk(d[7:2] & 6'h21, 6'h00);
            op(4'h1);
            rd(`PSC_ADDR);
            chk(d[2], 1'b1);
            op(4'h4);
            rd(`PSC_ADDR);
            chk(d[2], 1'b0);
            $display("source row %0d done", r);
        end
        wr(`GIE_ADDR, 8'hC6);
        pulse(6, 1);
        pulse(5, 1);
        pulse(1, 1);
        op(4'h2);
        for (int k = 0; k < 3; k++) begin
            serve(pv[k]);
            op(4'h1);
        end
        op(4'h4);
        wr(`GIE_ADDR, 8'h00);
        $display("priority test done");
        for (int k = 0; k < 2; k++) begin
            bus_activity <= (k == 0);
            wr(`PSC_ADDR, 8'h09);
            #1 chk(suspended, 1'b1);
            repeat (3) @(posedge clock);
            #1 chk({suspended, cpu_stall}, {k[0], 1'b1});
            @(posedge clock) bus_activity <= 1'b1;
            n = 0;
            while (cpu_stall !== 1'b0 && n < 100) begin
                @(posedge clock);
                #1 n++;
            end
            chk(cpu_stall, 1'b0);
            @(posedge clock) bus_activity <= 1'b0;
            rd(`PSC_ADDR);
            chk(d[3], 1'b0);
        end
        $display("suspend test done");
        wr(`GIE_ADDR, 8'hC7);
        wr(`PSC_ADDR, 8'h21);
        op(4'h8);
        repeat (5) @(posedge clock);
        #1 chk({running, cpu_stall}, 2'h1);
        @(posedge clock) watchdog_reset <= 1'b1;
        @(posedge clock) watchdog_reset <= 1'b0;
        rd(`PSC_ADDR);
        chk({d, running}, 9'h0C3);
        rd(`GIE_ADDR);
        chk(d, 8'h00);
        @(posedge clock) low_voltage_reset <= 1'b1;
        @(posedge clock) low_voltage_reset <= 1'b0;
        rd(`PSC_ADDR);
        chk(d, 8'h11);
        @(posedge clock) watchdog_reset <= 1'b1;
        @(posedge clock) watchdog_reset <= 1'b0;
        rd(`PSC_ADDR);
        chk(d, 8'h51);
        wr(`PSC_ADDR, 8'h50);
        #1 chk({running, cpu_stall}, 2'h1);
        $display("halt and reset test done");
        report_and_stop();
    end
endmodule
